// ### hw/pbc_pkg.sv
// Package for the pin bit control cell
package pbc_pkg;
  // ==========================================================
  // Register map
  localparam logic [7:0] PBC_OFS_CTRL    = 8'h00;
  localparam logic [7:0] PBC_OFS_SRC     = 8'h01;
  localparam logic [7:0] PBC_OFS_STATUS  = 8'h02;
  localparam logic [7:0] PBC_OFS_CLEAR   = 8'h03;
  localparam logic [7:0] PBC_OFS_ENABLE  = 8'h04;
  localparam logic [7:0] PBC_OFS_NONE    = 8'h00;
  // ==========================================================
  // Field positions
  localparam int PBC_BIT_DATA = 0;
  localparam int PBC_BIT_DIR  = 1;
  localparam int PBC_FS_LO    = 2;
  localparam int PBC_FS_HI    = 4;
  // ==========================================================
  // Reset values
  localparam logic [2:0] PBC_RST_FS   = 3'h0;
  localparam logic       PBC_RST_DIR  = 1'b1;
  localparam logic       PBC_RST_DATA = 1'b1;
  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS   = 10;
  localparam int FLASH_BASE_NS   = 10_000_000;
  localparam int FLASH_BASE_CYC  = FLASH_BASE_NS / CLK_PERIOD_NS;
  localparam int FILTER_CYC      = 4;
  // ==========================================================
  // Edge select codes
  typedef enum logic [2:0] {
    PBC_EDGE_NONE = 3'b000,
    PBC_EDGE_RISE = 3'b001,
    PBC_EDGE_FALL = 3'b010,
    PBC_EDGE_BOTH = 3'b011
  } pbc_edge_e;
endpackage : pbc_pkg

// ### hw/pbc_cell.sv
// Pin bit control cell: flashing output, filtered edge interrupt input
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// RULE_01 - As output, function select with direction and data chooses the pin toggle rate.
// RULE_02 - Output mode gives seven flash rates plus steady on and steady off.
// RULE_03 - As input, function select chooses which edge raises an interrupt.
// RULE_04 - Pin changes pass a filter and count only once the filter accepts them.
// RULE_05 - A valid selected edge asserts the low interrupt and loads the source register with the cell address.
// RULE_06 - Software should change direction and enable interrupts in separate writes.
// RULE_07 - Direction one makes an input, zero an output, each pin independent.
// RULE_08 - With data held fixed, toggling direction emulates open drain or open source.
// RULE_09 - After reset direction is one, an input with pull-up.
// RULE_10 - As output, written data sets the driven level.
// RULE_11 - As input, reading data returns the sampled pin level.
// RULE_12 - Reading data never returns the latch, always the pin.
// RULE_13 - After reset the data latch is one while reads return the pin.
// RULE_14 - Select encoding and filter length are fixed and documented.
module pbc_cell
  import pbc_pkg::*;
#(
  parameter logic [7:0] CELL_ADDR  = 8'hb0,
  parameter int         FLASH_BASE = FLASH_BASE_CYC,
  parameter int         FILT_LEN   = FILTER_CYC
) (
  input  wire logic       i_clk_sys,
  input  wire logic       i_resetn,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  input  wire logic       i_pin,
  output logic            o_pin,
  output logic            o_pin_oe,
  output logic            o_int_n
);
  // ==========================================================
  // Register state
  logic [2:0] fs_reg, fs_next;
  logic       dir_reg, dir_next;
  logic       dat_reg, dat_next;
  logic [7:0] src_reg, src_next;
  logic       sts_reg, sts_next;
  logic       ien_reg, ien_next;
  logic [7:0] rdata_reg, rdata_next;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // ==========================================================
  // Input filter
  logic [15:0] fcnt_reg, fcnt_next;
  logic        pin_q_reg, pin_q_next;
  logic        flt_reg, flt_next;
  logic        valid_edge;

  always_comb begin
    pin_q_next = i_pin;
    flt_next   = flt_reg;
    fcnt_next  = 16'h0000;
    if (pin_q_reg != flt_reg) begin // [RULE_04]
      fcnt_next = fcnt_reg + 16'h0001;
      if (fcnt_reg >= 16'(FILT_LEN - 1)) begin // [RULE_14]
        flt_next  = pin_q_reg;
        fcnt_next = 16'h0000;
      end
    end
  end

  always_comb begin
    valid_edge = 1'b0;
    if (dir_reg && flt_next != flt_reg) begin // [RULE_03]
      case (fs_reg)
        PBC_EDGE_RISE: valid_edge = flt_next;
        PBC_EDGE_FALL: valid_edge = !flt_next;
        PBC_EDGE_BOTH: valid_edge = 1'b1;
        default:       valid_edge = 1'b0;
      endcase
    end
  end

  // ==========================================================
  // Flash rate divider
  logic [31:0] div_reg, div_next;
  logic [6:0]  phase_reg, phase_next;
  logic        tick;
  logic        flash_lvl;

  always_comb begin
    tick     = (div_reg >= 32'(FLASH_BASE - 1));
    div_next = tick ? 32'h0 : div_reg + 32'h1;
    phase_next = tick ? phase_reg + 7'h01 : phase_reg;
  end

  // Codes 1..7 select half periods base*2^(code-1); 0 is steady
  always_comb begin
    case (fs_reg) // [RULE_01] [RULE_02] [RULE_14]
      3'h0:    flash_lvl = dat_reg;
      3'h1:    flash_lvl = phase_reg[0];
      3'h2:    flash_lvl = phase_reg[1];
      3'h3:    flash_lvl = phase_reg[2];
      3'h4:    flash_lvl = phase_reg[3];
      3'h5:    flash_lvl = phase_reg[4];
      3'h6:    flash_lvl = phase_reg[5];
      3'h7:    flash_lvl = phase_reg[6];
      default: flash_lvl = dat_reg;
    endcase
  end

  // ==========================================================
  // Register bus
  always_comb begin
    fs_next    = fs_reg;
    dir_next   = dir_reg;
    dat_next   = dat_reg;
    src_next   = src_reg;
    ien_next   = ien_reg;
    sts_next   = sts_reg;
    rdata_next = 8'h00;
    if (i_wr && hit(i_addr, PBC_OFS_CTRL)) begin
      fs_next  = i_wdata[PBC_FS_HI:PBC_FS_LO];
      dir_next = i_wdata[PBC_BIT_DIR]; // [RULE_07] [RULE_08]
      dat_next = i_wdata[PBC_BIT_DATA]; // [RULE_10]
    end
    if (i_wr && hit(i_addr, PBC_OFS_ENABLE))
      ien_next = i_wdata[0];
    if (i_wr && hit(i_addr, PBC_OFS_CLEAR) && i_wdata[0])
      sts_next = 1'b0;
    if (valid_edge) begin // [RULE_05]
      sts_next = 1'b1;
      src_next = CELL_ADDR;
    end
    if (i_rd) begin
      case (i_addr)
        PBC_OFS_CTRL:   rdata_next = {3'h0, fs_reg, dir_reg, pin_q_reg}; // [RULE_11] [RULE_12]
        PBC_OFS_SRC:    rdata_next = src_reg;
        PBC_OFS_STATUS: rdata_next = {7'h00, sts_reg};
        PBC_OFS_ENABLE: rdata_next = {7'h00, ien_reg};
        default:        rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      fs_reg    <= PBC_RST_FS;
      dir_reg   <= PBC_RST_DIR; // [RULE_09]
      dat_reg   <= PBC_RST_DATA; // [RULE_13]
      src_reg   <= PBC_OFS_NONE;
      sts_reg   <= 1'b0;
      ien_reg   <= 1'b0;
      rdata_reg <= 8'h00;
      fcnt_reg  <= 16'h0000;
      pin_q_reg <= 1'b1;
      flt_reg   <= 1'b1;
      div_reg   <= 32'h0;
      phase_reg <= 7'h00;
      o_pin     <= PBC_RST_DATA;
      o_pin_oe  <= 1'b0;
      o_int_n   <= 1'b1;
    end else begin
      fs_reg    <= fs_next;
      dir_reg   <= dir_next;
      dat_reg   <= dat_next;
      src_reg   <= src_next;
      sts_reg   <= sts_next;
      ien_reg   <= ien_next;
      rdata_reg <= rdata_next;
      fcnt_reg  <= fcnt_next;
      pin_q_reg <= pin_q_next;
      flt_reg   <= flt_next;
      div_reg   <= div_next;
      phase_reg <= phase_next;
      o_pin     <= flash_lvl; // [RULE_01] [RULE_10]
      o_pin_oe  <= !dir_next; // [RULE_07] [RULE_08]
      o_int_n   <= !(sts_next && ien_next); // [RULE_05]
    end
  end

  assign o_rdata = rdata_reg;

  // ==========================================================
  // Assertion helpers
  // Run length of the sampled pin level, saturating
  logic [7:0] run_reg, run_next;

  always_comb begin
    run_next = 8'h00;
    if (pin_q_next == pin_q_reg && run_reg != 8'hff)
      run_next = run_reg + 8'h01;
    else if (pin_q_next == pin_q_reg)
      run_next = run_reg;
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn)
      run_reg <= 8'h00;
    else
      run_reg <= run_next;
  end

  // ==========================================================
  // Assertions
  a_reset_dir_input: assert property (@(posedge i_clk_sys) // [RULE_09]
    $rose(i_resetn) |-> dir_reg && dat_reg && !o_pin_oe)
    else $error("direction not input after reset");
  a_input_no_drive: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // [RULE_07]
    dir_reg |=> !o_pin_oe || $past(i_wr))
    else $error("pin driven while input");
  a_read_pin: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // [RULE_12]
    i_rd && i_addr == PBC_OFS_CTRL |=> o_rdata[PBC_BIT_DATA] == $past(pin_q_reg))
    else $error("data read not from pin");
  a_src_addr: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // [RULE_05]
    valid_edge |=> src_reg == CELL_ADDR && sts_reg)
    else $error("source not loaded");
  a_int_level: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // [RULE_05]
    sts_reg && ien_reg |-> !o_int_n)
    else $error("interrupt not asserted");
  a_filter_gate: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // [RULE_04]
    flt_reg != $past(flt_reg) |-> $past(pin_q_reg) == flt_reg)
    else $error("filter took wrong level");
  a_steady_out: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // [RULE_02]
    fs_reg == 3'h0 && !dir_reg && $stable(dat_reg) |=> o_pin == $past(dat_reg))
    else $error("steady drive wrong");
  a_edge_input: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // [RULE_03]
    valid_edge |-> dir_reg && fs_reg != 3'h0)
    else $error("edge outside input mode");

  a_oe_follows_dir: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // [RULE_07]
    o_pin_oe == !dir_reg)
    else $error("drive enable not from direction");

  a_write_data: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // [RULE_10]
    i_wr && i_addr == PBC_OFS_CTRL |=> dat_reg == $past(i_wdata[PBC_BIT_DATA]))
    else $error("data latch not written");

  a_write_dir: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // [RULE_07]
    i_wr && i_addr == PBC_OFS_CTRL |=> dir_reg == $past(i_wdata[PBC_BIT_DIR]))
    else $error("direction not written");

  a_write_select: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // [RULE_01]
    i_wr && i_addr == PBC_OFS_CTRL |=> fs_reg == $past(i_wdata[PBC_FS_HI:PBC_FS_LO]))
    else $error("function select not written");

  a_open_drain: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // [RULE_08]
    i_wr && i_addr == PBC_OFS_CTRL |=> o_pin_oe == !$past(i_wdata[PBC_BIT_DIR]))
    else $error("direction write did not gate drive");

  a_flash_rate: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // [RULE_02]
    fs_reg != 3'h0 |=> o_pin == $past(phase_reg[fs_reg - 3'h1]))
    else $error("flash rate tap wrong");

  a_phase_step: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // [RULE_01]
    tick |=> phase_reg == $past(phase_reg) + 7'h01)
    else $error("flash phase did not step");

  a_div_range: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // [RULE_14]
    div_reg < 32'(FLASH_BASE))
    else $error("flash divider overran");

  a_filter_len: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // [RULE_04]
    flt_reg != $past(flt_reg) |-> $past(run_reg) >= 8'(FILT_LEN - 1))
    else $error("filter accepted a short pulse");

  a_fs_unused: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // [RULE_03]
    fs_reg[2] |-> !valid_edge)
    else $error("edge from unused select code");

  a_int_off: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // [RULE_05]
    !(sts_reg && ien_reg) |-> o_int_n)
    else $error("interrupt without enabled status");

  a_set_wins: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // [RULE_05]
    valid_edge && i_wr && i_addr == PBC_OFS_CLEAR |=> sts_reg)
    else $error("clear beat a new event");

  a_src_hold: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // [RULE_05]
    !valid_edge |=> $stable(src_reg))
    else $error("source changed without event");

  a_rdata_idle: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // [RULE_11]
    !i_rd |=> o_rdata == 8'h00)
    else $error("read data not cleared");

  a_read_fields: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // [RULE_07]
    i_rd && i_addr == PBC_OFS_CTRL |=> o_rdata[PBC_FS_HI:PBC_BIT_DIR] == $past({fs_reg, dir_reg}))
    else $error("control read wrong");

  a_read_status: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // [RULE_05]
    i_rd && i_addr == PBC_OFS_STATUS |=> o_rdata == {7'h00, $past(sts_reg)})
    else $error("status read wrong");

  a_reset_quiet: assert property (@(posedge i_clk_sys) // [RULE_09]
    $rose(i_resetn) |-> o_int_n && o_rdata == 8'h00)
    else $error("outputs not idle after reset");

  // ==========================================================
  // Cover points
  c_int_fire: cover property (@(posedge i_clk_sys) $fell(o_int_n));
  c_out_drive: cover property (@(posedge i_clk_sys) $rose(o_pin_oe));
  c_flash: cover property (@(posedge i_clk_sys) !dir_reg && fs_reg != 3'h0 && $changed(o_pin));
  c_glitch_drop: cover property (@(posedge i_clk_sys) fcnt_reg != 16'h0000 && pin_q_reg == flt_reg);
endmodule : pbc_cell
`default_nettype wire

// ### tb/pbc_pin_model.sv
// Pad model: weak pull-up and an external driver
`timescale 1ns/1ps
`default_nettype none
module pbc_pin_model (
  input  wire logic i_pin_drv,
  input  wire logic i_pin_oe,
  input  wire logic i_ext_en,
  input  wire logic i_ext_val,
  output logic      o_pad
);
  // ==========
  // Pad level
  assign o_pad = i_pin_oe ? i_pin_drv : (i_ext_en ? i_ext_val : 1'b1);
endmodule : pbc_pin_model
`default_nettype wire

// ### tb/pbc_cell_tb.sv
// Self-checking bench for the pin bit control cell
`timescale 1ns/1ps
`default_nettype none
module pbc_cell_tb;
  import pbc_pkg::*;
  localparam logic [7:0] ADDR = 8'hb0;
  localparam int         FB   = 4;
  logic       clk, rstn, wr, rd, pin, opin, oe, intn, ext_en, ext_v;
  logic [7:0] addr, wdata, rdata, v;
  int         miscompares, n_compared, h, c;
  int         half_q[$];
  // ==========
  // Design and pad
  pbc_cell #(.CELL_ADDR(ADDR), .FLASH_BASE(FB), .FILT_LEN(FILTER_CYC)) i_pbc_cell (
    .i_clk_sys(clk), .i_resetn(rstn), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .i_pin(pin), .o_pin(opin), .o_pin_oe(oe), .o_int_n(intn));
  pbc_pin_model i_pbc_pin_model (.i_pin_drv(opin), .i_pin_oe(oe), .i_ext_en(ext_en),
    .i_ext_val(ext_v), .o_pad(pin));
  always #5 clk = ~clk;
  // ==========
  // Tasks
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wrr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) begin
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
    end
    @(posedge clk) wr <= 1'b0;
  endtask : wrr
  task automatic rdr(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk) begin
      addr <= a;
      rd   <= 1'b1;
    end
    @(posedge clk) rd <= 1'b0;
    #1 d = rdata;
  endtask : rdr
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic end_of_test();
    $display("Compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test
  // Edge model: 1 rise, 2 fall, 3 both
  function automatic int ev(input int f, input int r);
    return int'((f == 1 && r == 1) || (f == 2 && r == 0) || f == 3);
  endfunction : ev
  // ==========
  // Watchdog
  initial begin
    #500000;
    miscompares++;
    end_of_test();
  end
  // ==========
  // Main sequence
  initial begin
    {clk, rstn, wr, rd, ext_en, ext_v} = '0;
    {addr, wdata} = '0;
    miscompares = 0;
    n_compared = 0;
    void'($urandom(32'h92b57303));
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    cyc(1);
    chk(16'({oe, intn}), 16'h1);
    rdr(PBC_OFS_CTRL, v); chk(v, 8'h03);
    cyc(1); chk(16'(rdata), 16'h0);
    rdr(PBC_OFS_SRC, v); chk(v, 8'h00);
    h = $urandom_range(255, 5);
    wrr(8'(h), 8'($urandom));
    rdr(8'(h), v); chk(v, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wrr(PBC_OFS_CTRL, 8'(i));
      cyc(2);
      rdr(PBC_OFS_CTRL, v); chk(v, i[1] ? 8'h03 : 8'(i));
      chk(16'(oe), 16'(!i[1]));
    end
    @(posedge clk) ext_en <= 1'b1;
    repeat (8) begin
      @(posedge clk) ext_v <= 1'($urandom);
      cyc(3);
      rdr(PBC_OFS_CTRL, v); chk(v, {7'h01, ext_v});
    end
    @(posedge clk) ext_en <= 1'b0;
    wrr(PBC_OFS_CTRL, 8'h01);
    cyc(40);
    chk(16'(opin), 16'h1);
    for (int n = 1; n < 8; n++) begin
      half_q.push_back(FB << (n - 1));
      wrr(PBC_OFS_CTRL, 8'(n << 2));
      cyc(1);
      repeat (3) begin
        v[0] = opin;
        c = 0;
        while (opin === v[0] && c < 600) begin
          cyc(1);
          c++;
        end
      end
      chk(16'(c), 16'(half_q[$]));
    end
    @(posedge clk) begin
      ext_en <= 1'b1;
      ext_v  <= 1'b0;
    end
    wrr(PBC_OFS_CTRL, 8'h02);
    wrr(PBC_OFS_ENABLE, 8'h01);
    for (int f = 0; f < 8; f++) begin
      wrr(PBC_OFS_CTRL, 8'(f << 2) | 8'h02);
      for (int e = 0; e < 2; e++) begin
        wrr(PBC_OFS_CLEAR, 8'h01);
        @(posedge clk) ext_v <= !e[0];
        cyc(2);
        @(posedge clk) ext_v <= e[0];
        cyc(10);
        rdr(PBC_OFS_STATUS, v); chk(v, 8'h00);
        @(posedge clk) ext_v <= !e[0];
        cyc(10);
        rdr(PBC_OFS_STATUS, v); chk(v, 8'(ev(f, 1 - e)));
        chk(16'(intn), 16'(1 - ev(f, 1 - e)));
        if (ev(f, 1 - e) == 1) begin
          rdr(PBC_OFS_SRC, v); chk(v, ADDR);
        end
      end
    end
    wrr(PBC_OFS_CTRL, 8'h0e);
    wrr(PBC_OFS_ENABLE, 8'h00);
    wrr(PBC_OFS_CLEAR, 8'h01);
    @(posedge clk) ext_v <= 1'b1;
    cyc(10);
    rdr(PBC_OFS_STATUS, v); chk({v, 7'h0, intn}, 16'h0101);
    wrr(PBC_OFS_ENABLE, 8'h01);
    cyc(2);
    chk(16'(intn), 16'h0);
    wrr(PBC_OFS_CLEAR, 8'h01);
    cyc(2);
    chk(16'(intn), 16'h1);
    end_of_test();
  end
endmodule : pbc_cell_tb
`default_nettype wire
